// *** core/pmrc_i2c_target.sv ***
`timescale 1ns/1ps
module pmrc_i2c_target #(
    parameter logic [6:0] DEV_ADDR = pmrc_pkg::DEV_ADDR_DEF
) (
    input  wire logic            clk_i,
    input  wire logic            srst_i,
    input  wire logic            scl_i,
    input  wire logic            sda_i,
    output logic                 sda_o,
    output logic                 sda_oe_o,
    pmrc_regbus_if.engine        bus
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] scl_m;
    logic [1:0] sda_m;
    logic       scl_p;
    logic       sda_p;

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            scl_m <= 2'h3;
            sda_m <= 2'h3;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end
        else
        begin
            scl_m <= {scl_m[0], scl_i};
            sda_m <= {sda_m[0], sda_i};
            scl_p <= scl_m[1];
            sda_p <= sda_m[1];
        end
    end

    logic start_c;
    logic stop_c;
    logic rise_c;
    logic fall_c;
    assign start_c = scl_m[1] & scl_p & sda_p & ~sda_m[1];
    assign stop_c  = scl_m[1] & scl_p & ~sda_p & sda_m[1];
    assign rise_c  = scl_m[1] & ~scl_p;
    assign fall_c  = ~scl_m[1] & scl_p;

    // ------------------------------------------------------------
    // Byte engine
    // ------------------------------------------------------------
    pmrc_pkg::pmrc_phase_e phase, next_phase;
    logic [3:0] cnt, next_cnt;
    logic [7:0] sh, next_sh;
    logic [7:0] ptr, next_ptr;
    logic       rw, next_rw;
    logic       nack, next_nack;
    logic       oe, next_oe;
    logic       we, next_we;

    always_comb
    begin
        next_phase = phase;
        next_cnt   = cnt;
        next_sh    = sh;
        next_ptr   = ptr;
        next_rw    = rw;
        next_nack  = nack;
        next_oe    = oe;
        next_we    = 1'b0;
        if (start_c)
        begin
            next_phase = pmrc_pkg::PH_ADDR;
            // Clock fall that closes the start only primes the bit counter
            next_cnt   = '1;
            next_oe    = 1'b0;
        end
        else if (stop_c)
        begin
            next_phase = pmrc_pkg::PH_IDLE;
            next_oe    = 1'b0;
        end
        else if (phase != pmrc_pkg::PH_IDLE && rise_c)
        begin
            if (cnt == pmrc_pkg::BIT_ACK)
                next_nack = sda_m[1];
            else if (phase != pmrc_pkg::PH_RD)
                next_sh = {sh[6:0], sda_m[1]};
        end
        else if (phase != pmrc_pkg::PH_IDLE && fall_c)
        begin
            if (cnt == pmrc_pkg::BIT_LAST)
            begin
                next_cnt = pmrc_pkg::BIT_ACK;
                next_oe  = (phase != pmrc_pkg::PH_RD);
                if (phase == pmrc_pkg::PH_ADDR)
                begin
                    next_rw = sh[0];
                    // Other targets' traffic is ignored until next start
                    if (sh[7:1] != DEV_ADDR)
                    begin
                        next_phase = pmrc_pkg::PH_IDLE;
                        next_oe    = 1'b0;
                    end
                end
                if (phase == pmrc_pkg::PH_PTR)
                    next_ptr = sh;
                if (phase == pmrc_pkg::PH_WR)
                    next_we = 1'b1;
            end
            else if (cnt == pmrc_pkg::BIT_ACK)
            begin
                next_cnt = 4'h0;
                next_oe  = 1'b0;
                if (phase == pmrc_pkg::PH_ADDR && !rw)
                    next_phase = pmrc_pkg::PH_PTR;
                else if (phase == pmrc_pkg::PH_PTR)
                    next_phase = pmrc_pkg::PH_WR;
                else if (phase == pmrc_pkg::PH_WR)
                    next_ptr = 8'(ptr + 8'h01);
                else if (phase == pmrc_pkg::PH_RD && nack)
                    next_phase = pmrc_pkg::PH_IDLE;
                else
                begin
                    // Read start or acked read byte: fetch and drive msb
                    next_phase = pmrc_pkg::PH_RD;
                    next_sh    = bus.rdata;
                    next_oe    = ~bus.rdata[7];
                    next_ptr   = 8'(ptr + 8'h01);
                end
            end
            else
            begin
                next_cnt = 4'(cnt + 4'h1);
                if (phase == pmrc_pkg::PH_RD)
                begin
                    next_sh = {sh[6:0], 1'b0};
                    next_oe = ~sh[6];
                end
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            phase    <= pmrc_pkg::PH_IDLE;
            cnt      <= 4'h0;
            sh       <= 8'h00;
            ptr      <= 8'h00;
            rw       <= 1'b0;
            nack     <= 1'b0;
            oe       <= 1'b0;
            we       <= 1'b0;
            sda_o    <= 1'b0;
            sda_oe_o <= 1'b0;
        end
        else
        begin
            phase    <= next_phase;
            cnt      <= next_cnt;
            sh       <= next_sh;
            ptr      <= next_ptr;
            rw       <= next_rw;
            nack     <= next_nack;
            oe       <= next_oe;
            we       <= next_we;
            sda_o    <= 1'b0;
            sda_oe_o <= next_oe;
        end
    end

    assign bus.addr  = ptr;
    assign bus.wdata = sh;
    assign bus.we    = we;

endmodule

// *** core/pmrc_pkg.sv ***
package pmrc_pkg;

    // ------------------------------------------------------------
    // Register offsets and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_DSC3  = 8'h42;
    localparam logic [7:0] OFS_PGD   = 8'h43;
    localparam logic [7:0] OFS_SHUTDOWN_TRIGGER_BIT  = 8'h91;
    localparam logic [7:0] OFS_R2SLP = 8'h93;
    localparam logic [7:0] OFS_R4    = 8'h94;
    localparam logic [7:0] OFS_R4SLP = 8'h95;
    localparam logic [7:0] OFS_R5    = 8'h96;

    localparam logic [7:0] DSC3_RST  = 8'h15;
    localparam logic [7:0] PGD_RST   = 8'h00;
    localparam logic [7:0] SHUTDOWN_TRIGGER_BIT_RST  = 8'h00;
    localparam logic [7:0] R2SLP_RST = 8'h50;
    localparam logic [7:0] R4_RST    = 8'h20;
    localparam logic [7:0] R4SLP_RST = 8'h20;
    localparam logic [7:0] R5_RST    = 8'h70;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int NUM_DSC  = 3;
    localparam int DSC_W    = 2;
    localparam int PGD_W    = 3;
    localparam int VID_W    = 7;
    localparam int VID_LSB  = 1;
    localparam int FLAG_BIT = 0;
    localparam logic [DSC_W-1:0] DSC_OFF = 2'h0;

    // ------------------------------------------------------------
    // Power-good delay timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int          PG_CNT_W      = 24;
    typedef int unsigned pmrc_delay_t [8];
    localparam pmrc_delay_t PG_DELAY_US = '{2500, 5000, 10000, 15000,
                                            20000, 50000, 75000, 100000};

    // Least times, so rounded up
    function automatic pmrc_delay_t pg_cycles();
        pmrc_delay_t c;
        for (int i = 0; i < 8; i++)
        begin
            c[i] = (PG_DELAY_US[i] * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        end
        return c;
    endfunction
    localparam pmrc_delay_t PG_DELAY_CYC = pg_cycles();

    // ------------------------------------------------------------
    // Two-wire target
    // ------------------------------------------------------------
    localparam logic [6:0] DEV_ADDR_DEF = 7'h5E; // Arbitrary value
    localparam logic [3:0] BIT_LAST     = 4'h7;
    localparam logic [3:0] BIT_ACK      = 4'h8;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_ADDR = 3'b001,
        PH_PTR  = 3'b011,
        PH_WR   = 3'b010,
        PH_RD   = 3'b110
    } pmrc_phase_e;

    typedef struct packed {
        logic [NUM_DSC-1:0][DSC_W-1:0] dsc;
        logic [PGD_W-1:0]              pg_code;
        logic                          shutdown_trigger_bit;
        logic [VID_W-1:0]              r2_slp_code;
        logic                          r2_slp_en;
        logic [VID_W-1:0]              r4_code;
        logic                          r4_decay;
        logic [VID_W-1:0]              r4_slp_code;
        logic [VID_W-1:0]              r5_code;
        logic                          r5_decay;
    } pmrc_regs_s;

    localparam pmrc_regs_s REGS_RST = '{
        dsc:         DSC3_RST[NUM_DSC*DSC_W-1:0],
        pg_code:     PGD_RST[PGD_W-1:0],
        shutdown_trigger_bit:        SHUTDOWN_TRIGGER_BIT_RST[FLAG_BIT],
        r2_slp_code: R2SLP_RST[VID_LSB +: VID_W],
        r2_slp_en:   R2SLP_RST[FLAG_BIT],
        r4_code:     R4_RST[VID_LSB +: VID_W],
        r4_decay:    R4_RST[FLAG_BIT],
        r4_slp_code: R4SLP_RST[VID_LSB +: VID_W],
        r5_code:     R5_RST[VID_LSB +: VID_W],
        r5_decay:    R5_RST[FLAG_BIT]
    };

endpackage

// *** core/pmrc_rail_ctrl.sv ***
`timescale 1ns/1ps
module pmrc_rail_ctrl #(
    parameter logic [6:0]  DEV_ADDR      = pmrc_pkg::DEV_ADDR_DEF,
    parameter bit          SLEEP_PIN_SEL = 1'b0,
    parameter int unsigned PG_DELAY_CYC [8] = pmrc_pkg::PG_DELAY_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    input  wire logic [2:0]  rail_enable_i,
    input  wire logic        out3_rails_good_i,
    input  wire logic        out3_host_ctrl_i,
    input  wire logic        out3_host_value_i,
    input  wire logic        sleep_request_pin_one_i,
    input  wire logic        sleep_request_pin_two_i,
    input  wire logic [6:0]  rail2_normal_code_i,
    input  wire logic        rail4_sleep_enable_i,
    output logic [5:0]       discharge_sel_o,
    output logic             general_output_three_o,
    output logic             shutdown_o,
    output logic [6:0]       rail2_target_code_o,
    output logic [6:0]       rail4_target_code_o,
    output logic             rail4_decay_select_o,
    output logic [6:0]       rail5_target_code_o,
    output logic             rail5_decay_select_o
);

    // ------------------------------------------------------------
    // Register access engine
    // ------------------------------------------------------------
    pmrc_regbus_if bus ();

    pmrc_i2c_target #(
        .DEV_ADDR (DEV_ADDR)
    ) u_target (
        .clk_i    (clk_i),
        .srst_i   (srst_i),
        .scl_i    (scl_i),
        .sda_i    (sda_i),
        .sda_o    (sda_o),
        .sda_oe_o (sda_oe_o),
        .bus      (bus)
    );

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] pin_m;
    logic [2:0] pin_s;
    logic       good_s;
    logic       sleep_req_s;

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            pin_m <= 3'h0;
            pin_s <= 3'h0;
        end
        else
        begin
            pin_m <= {out3_rails_good_i, sleep_request_pin_two_i, sleep_request_pin_one_i};
            pin_s <= pin_m;
        end
    end

    assign good_s      = pin_s[2];
    // Pin choice is fixed at build time, like a factory trim
    assign sleep_req_s = SLEEP_PIN_SEL ? pin_s[1] : pin_s[0];

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    pmrc_pkg::pmrc_regs_s regs, next_regs;

    always_comb
    begin
        next_regs      = regs;
        next_regs.shutdown_trigger_bit = 1'b0;
        if (bus.we)
        begin
            // Only implemented fields are stored
            case (bus.addr)
                pmrc_pkg::OFS_DSC3:
                    next_regs.dsc = bus.wdata[pmrc_pkg::NUM_DSC*pmrc_pkg::DSC_W-1:0];
                pmrc_pkg::OFS_PGD:
                    next_regs.pg_code = bus.wdata[pmrc_pkg::PGD_W-1:0];
                pmrc_pkg::OFS_SHUTDOWN_TRIGGER_BIT:
                    next_regs.shutdown_trigger_bit = bus.wdata[pmrc_pkg::FLAG_BIT];
                pmrc_pkg::OFS_R2SLP:
                begin
                    next_regs.r2_slp_code = bus.wdata[pmrc_pkg::VID_LSB +: pmrc_pkg::VID_W];
                    next_regs.r2_slp_en   = bus.wdata[pmrc_pkg::FLAG_BIT];
                end
                pmrc_pkg::OFS_R4:
                begin
                    next_regs.r4_code  = bus.wdata[pmrc_pkg::VID_LSB +: pmrc_pkg::VID_W];
                    next_regs.r4_decay = bus.wdata[pmrc_pkg::FLAG_BIT];
                end
                pmrc_pkg::OFS_R4SLP:
                    next_regs.r4_slp_code = bus.wdata[pmrc_pkg::VID_LSB +: pmrc_pkg::VID_W];
                pmrc_pkg::OFS_R5:
                begin
                    next_regs.r5_code  = bus.wdata[pmrc_pkg::VID_LSB +: pmrc_pkg::VID_W];
                    next_regs.r5_decay = bus.wdata[pmrc_pkg::FLAG_BIT];
                end
                default:
                    next_regs = next_regs;
            endcase
        end
        // Hardware clear beats a host write in the same cycle
        for (int i = 0; i < pmrc_pkg::NUM_DSC; i++)
        begin
            if (rail_enable_i[i])
                next_regs.dsc[i] = pmrc_pkg::DSC_OFF;
        end
        // Shutdown one cycle after the write wipes the whole bank
        if (regs.shutdown_trigger_bit)
            next_regs = pmrc_pkg::REGS_RST;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            regs <= pmrc_pkg::REGS_RST;
        else
            regs <= next_regs;
    end

    // Unmapped offsets and reserved bits read as zero
    always_comb
    begin
        bus.rdata = pmrc_pkg::READ_ZERO;
        case (bus.addr)
            pmrc_pkg::OFS_DSC3:  bus.rdata = {2'h0, regs.dsc};
            pmrc_pkg::OFS_PGD:   bus.rdata = {5'h00, regs.pg_code};
            pmrc_pkg::OFS_SHUTDOWN_TRIGGER_BIT:  bus.rdata = pmrc_pkg::READ_ZERO;
            pmrc_pkg::OFS_R2SLP: bus.rdata = {regs.r2_slp_code, regs.r2_slp_en};
            pmrc_pkg::OFS_R4:    bus.rdata = {regs.r4_code, regs.r4_decay};
            pmrc_pkg::OFS_R4SLP: bus.rdata = {regs.r4_slp_code, 1'b0};
            pmrc_pkg::OFS_R5:    bus.rdata = {regs.r5_code, regs.r5_decay};
            default:             bus.rdata = pmrc_pkg::READ_ZERO;
        endcase
    end

    // ------------------------------------------------------------
    // Power-good delay for output three
    // ------------------------------------------------------------
    logic [pmrc_pkg::PG_CNT_W-1:0] pg_cnt, next_pg_cnt;
    logic [pmrc_pkg::PG_CNT_W-1:0] pg_limit;
    logic                          next_out3;

    assign pg_limit = pmrc_pkg::PG_CNT_W'(PG_DELAY_CYC[regs.pg_code]);

    always_comb
    begin
        next_pg_cnt = pg_cnt;
        if (!good_s || out3_host_ctrl_i)
            next_pg_cnt = '0;
        else if (pg_cnt < pg_limit)
            next_pg_cnt = pmrc_pkg::PG_CNT_W'(pg_cnt + 1'b1);
        // Direct host drive bypasses the timer entirely
        if (out3_host_ctrl_i)
            next_out3 = out3_host_value_i;
        else
            next_out3 = good_s && (pg_cnt >= pg_limit);
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            pg_cnt                 <= '0;
            general_output_three_o <= 1'b0;
        end
        else
        begin
            pg_cnt                 <= next_pg_cnt;
            general_output_three_o <= next_out3;
        end
    end

    // ------------------------------------------------------------
    // Rail targets
    // ------------------------------------------------------------
    logic [6:0] next_r2_tgt;
    logic [6:0] next_r4_tgt;

    always_comb
    begin
        next_r2_tgt = (regs.r2_slp_en && sleep_req_s) ? regs.r2_slp_code
                                                      : rail2_normal_code_i;
        next_r4_tgt = (rail4_sleep_enable_i && sleep_req_s) ? regs.r4_slp_code
                                                            : regs.r4_code;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            rail2_target_code_o <= pmrc_pkg::R2SLP_RST[pmrc_pkg::VID_LSB +: pmrc_pkg::VID_W];
            rail4_target_code_o <= pmrc_pkg::REGS_RST.r4_code;
        end
        else
        begin
            rail2_target_code_o <= next_r2_tgt;
            rail4_target_code_o <= next_r4_tgt;
        end
    end

    assign discharge_sel_o      = regs.dsc;
    assign shutdown_o           = regs.shutdown_trigger_bit;
    assign rail4_decay_select_o = regs.r4_decay;
    assign rail5_target_code_o  = regs.r5_code;
    assign rail5_decay_select_o = regs.r5_decay;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    // Helper: cycles the grouped rails have been good in timer mode
    logic [pmrc_pkg::PG_CNT_W-1:0] good_run;
    always_ff @(posedge clk_i)
    begin
        if (srst_i || !good_s || out3_host_ctrl_i)
            good_run <= '0;
        else if (good_run != '1)
            good_run <= pmrc_pkg::PG_CNT_W'(good_run + 1'b1);
    end

    // An enabled rail 2 forces its discharge field off unless a shutdown wipe is pending
    AST_DSC_CLEAR: assert property (rail_enable_i[2] && !regs.shutdown_trigger_bit
        |=> regs.dsc[2] == pmrc_pkg::DSC_OFF)
        else $error("discharge field not cleared while rail enabled");
    AST_DSC_RESET: assert property ($fell(srst_i) |->
        {2'h0, regs.dsc} == pmrc_pkg::DSC3_RST)
        else $error("discharge register reset value wrong");
    AST_PG_EARLY: assert property (general_output_three_o && !$past(out3_host_ctrl_i)
        |-> $past(good_run) >= $past(pg_limit))
        else $error("power good asserted before delay expired");
    AST_PG_DROP: assert property (!good_s && !out3_host_ctrl_i |=> !general_output_three_o)
        else $error("power good held without grouped rails");
    AST_HOST_OUT: assert property (out3_host_ctrl_i ##1 out3_host_ctrl_i
        |-> general_output_three_o == $past(out3_host_value_i))
        else $error("host-driven output does not follow host value");
    AST_SHUTDOWN_TRIGGER_BIT_WIPE: assert property (bus.we && bus.addr == pmrc_pkg::OFS_SHUTDOWN_TRIGGER_BIT &&
        bus.wdata[pmrc_pkg::FLAG_BIT] |=> shutdown_o ##1 regs == pmrc_pkg::REGS_RST)
        else $error("shutdown did not restore reset values");
    AST_SHUTDOWN_TRIGGER_BIT_SELFCLR: assert property (shutdown_o |=> !shutdown_o)
        else $error("shutdown bit did not self-clear");
    AST_SHUTDOWN_TRIGGER_BIT_READ: assert property (bus.addr == pmrc_pkg::OFS_SHUTDOWN_TRIGGER_BIT |-> bus.rdata == 8'h00)
        else $error("shutdown register read nonzero");
    AST_R2_RESET: assert property ($fell(srst_i) |->
        {regs.r2_slp_code, regs.r2_slp_en} == pmrc_pkg::R2SLP_RST)
        else $error("rail2 sleep register reset wrong");
    AST_R4_WRITE: assert property (bus.we && bus.addr == pmrc_pkg::OFS_R4 && !regs.shutdown_trigger_bit
        |=> {regs.r4_code, rail4_decay_select_o} == $past(bus.wdata))
        else $error("rail4 register write lost");
    AST_R45_RESET: assert property ($fell(srst_i) |-> {regs.r4_code, regs.r4_decay} ==
        pmrc_pkg::R4_RST && {regs.r5_code, regs.r5_decay} == pmrc_pkg::R5_RST)
        else $error("rail4 or rail5 reset wrong");
    AST_R4SLP_RSV: assert property (bus.addr == pmrc_pkg::OFS_R4SLP |-> !bus.rdata[0])
        else $error("rail4 sleep reserved bit reads one");
    AST_SLEEP_SEL: assert property (regs.r2_slp_en && sleep_req_s
        |=> rail2_target_code_o == $past(regs.r2_slp_code))
        else $error("rail2 target ignores sleep request");

    COV_PG_RISE:  cover property (!out3_host_ctrl_i && $rose(general_output_three_o));
    COV_SHUTDOWN_TRIGGER_BIT:     cover property (shutdown_o);
    COV_SLEEP:    cover property (regs.r2_slp_en && sleep_req_s);
    COV_DSC_FORCE: cover property (bus.we && bus.addr == pmrc_pkg::OFS_DSC3 && rail_enable_i[1]);

endmodule

// *** core/pmrc_regbus_if.sv ***
`timescale 1ns/1ps
interface pmrc_regbus_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic [7:0] rdata;

    modport engine (output addr, output wdata, output we, input rdata);
    modport regs   (input addr, input wdata, input we, output rdata);
endinterface

// *** tb/pmrc_host.sv ***
`timescale 1ns/1ps
module pmrc_host (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_oe_o
);
    // Open drain on SDA only: only pulls low, line floats high when released; SCL is driven both high and low
    initial
    begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    task automatic half();
        repeat (8) @(posedge clk_i);
    endtask
    task automatic start();
        sda_oe_o <= 1'b0;
        half();
        scl_o <= 1'b1;
        half();
        sda_oe_o <= 1'b1;
        half();
        scl_o <= 1'b0;
    endtask
    // Nine bits MSB first; a 1 releases the line, so also reads and acks
    task automatic bits(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--)
        begin
            half();
            sda_oe_o <= ~tx[i];
            half();
            scl_o <= 1'b1;
            half();
            rx[i] = sda_i;
            scl_o <= 1'b0;
        end
    endtask
    task automatic head(input logic [7:0] ptr);
        logic [8:0] rx;
        start();
        bits({pmrc_pkg::DEV_ADDR_DEF, 2'b01}, rx);
        bits({ptr, 1'b1}, rx);
    endtask
    task automatic stop();
        half();
        sda_oe_o <= 1'b1;
        half();
        scl_o <= 1'b1;
        half();
        sda_oe_o <= 1'b0;
        half();
    endtask
    task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
        logic [8:0] rx;
        head(ptr);
        bits({data, 1'b1}, rx);
        stop();
    endtask
    task automatic rd(input logic [7:0] ptr, output logic [7:0] data);
        logic [8:0] rx;
        head(ptr);
        start();
        bits({pmrc_pkg::DEV_ADDR_DEF, 2'b11}, rx);
        bits(9'h1FF, rx);
        data = rx[8:1];
        stop();
    endtask
endmodule

// *** tb/test_pmrc_rail_ctrl.sv ***
`timescale 1ns/1ps
module test_pmrc_rail_ctrl;
    logic clk_i = 1'b0, srst_i = 1'b1, scl, h_oe, sda_o, d_oe, gout, sdn, r4d, r5d;
    logic good = 1'b0, hctl = 1'b0, hval = 1'b0, pin1 = 1'b0, r4s = 1'b0;
    logic [2:0] ren = 3'h0;
    logic [5:0] dsel;
    logic [6:0] r2t, r4t, r5t;
    logic [7:0] ofs [7] = '{8'h42, 8'h43, 8'h91, 8'h93, 8'h94, 8'h95, 8'h96};
    logic [7:0] rst [7] = '{8'h15, 8'h00, 8'h00, 8'h50, 8'h20, 8'h20, 8'h70};
    logic [7:0] msk [7] = '{8'h3F, 8'h07, 8'h00, 8'hFF, 8'hFF, 8'hFE, 8'hFF};
    int n_errors = 0, total_checks = 0;
    int n_sdn = 0;
    always @(posedge clk_i) if (sdn === 1'b1) n_sdn++;
    wire sda = ~(h_oe | d_oe);
    always #4 clk_i = ~clk_i;
    pmrc_host pmrc_host_inst (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(h_oe));
    pmrc_rail_ctrl #(.PG_DELAY_CYC('{10, 20, 30, 40, 50, 60, 70, 80})) pmrc_rail_ctrl_inst (
        .clk_i(clk_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_o(d_oe), .rail_enable_i(ren), .out3_rails_good_i(good),
        .out3_host_ctrl_i(hctl), .out3_host_value_i(hval), .sleep_request_pin_one_i(pin1),
        .sleep_request_pin_two_i(1'b0), .rail2_normal_code_i(7'h11),
        .rail4_sleep_enable_i(r4s), .discharge_sel_o(dsel), .general_output_three_o(gout),
        .shutdown_o(sdn), .rail2_target_code_o(r2t), .rail4_target_code_o(r4t),
        .rail4_decay_select_o(r4d), .rail5_target_code_o(r5t), .rail5_decay_select_o(r5d));
    task automatic print_verdict();
        if (n_errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] ptr, input logic [7:0] exp);
        logic [7:0] d;
        pmrc_host_inst.rd(ptr, d);
        chk(d, exp);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        for (int i = 0; i < 7; i++)
            rchk(ofs[i], rst[i]);
        for (int i = 0; i < 7; i++)
            if (i != 2) pmrc_host_inst.wr(ofs[i], 8'hFF);
        for (int i = 0; i < 7; i++)
            rchk(ofs[i], msk[i]);
        rchk(8'h44, 8'h00);
        chk({r4t, r4d}, 8'hFF);
        chk({r5t, r5d}, 8'hFF);
        chk({1'b0, r2t}, 8'h11);
        pin1 <= 1'b1;
        r4s <= 1'b1;
        pmrc_host_inst.wr(8'h95, 8'h0B);
        rchk(8'h95, 8'h0A);
        chk({1'b0, r2t}, 8'h7F);
        chk({1'b0, r4t}, 8'h05);
        ren <= 3'b110;
        pmrc_host_inst.wr(8'h42, 8'hFF);
        rchk(8'h42, 8'h03);
        chk({2'h0, dsel}, 8'h03);
        ren <= 3'b000;
        pmrc_host_inst.wr(8'h43, 8'h03);
        good <= 1'b1;
        repeat (35) @(posedge clk_i);
        chk({7'h0, gout}, 8'h00);
        repeat (12) @(posedge clk_i);
        chk({7'h0, gout}, 8'h01);
        hctl <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk({7'h0, gout}, 8'h00);
        pmrc_host_inst.wr(8'h91, 8'h00);
        rchk(8'h93, 8'hFF);
        chk(8'(n_sdn), 8'h00);
        pmrc_host_inst.wr(8'h91, 8'h01);
        chk(8'(n_sdn), 8'h01);
        rchk(8'h91, 8'h00);
        rchk(8'h93, 8'h50);
        rchk(8'h42, 8'h15);
        print_verdict();
    end
    initial
    begin
        repeat (60000) @(posedge clk_i);
        n_errors++;
        print_verdict();
    end
endmodule
